/* File: verilog/timer_map.vh */
// register offsets, field positions, reset values and mode codes of the
// timer control block; definitions only, included by the timer files
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// register addresses on the byte-wide register port
`define ADDR_W 12
`define ADDR_COUNT_HI 12'hF00
`define ADDR_COUNT_LO 12'hF01
`define ADDR_RELOAD_HI 12'hF02
`define ADDR_RELOAD_LO 12'hF03
`define ADDR_PWM_HI 12'hF04
`define ADDR_PWM_LO 12'hF05
`define ADDR_CTL0 12'hF06
`define ADDR_CTL1 12'hF07
`define ADDR_IRQ_STATUS 12'hF08
`define ADDR_IRQ_MASK 12'hF09

// timer_control_one fields
`define RUN_ENABLE_BIT 7
`define IO_POLARITY_BIT 6
`define PRESCALE_HI 5
`define PRESCALE_LO 3
`define MODE_SELECT_HI 2
`define MODE_SELECT_LO 0
// control zero: high bit of the mode code
`define MODE_HIGH_BIT 7

// reset, restart and step values
`define CTL_RESET 8'h00
`define COUNT_RESET 16'h0001
`define RELOAD_RESET 16'hFFFF
`define PWM_RESET 16'h0000
`define COUNT_RESTART 16'h0001
`define COUNT_STEP 16'h0001
`define BYTE_ZERO 8'h00

// interrupt status and mask layout
`define IRQ_W 3
`define IRQ_RELOAD 0
`define IRQ_CAPTURE 1
`define IRQ_GATE 2
`define IRQ_ZERO 3'h0

// four-bit mode codes
`define MODE_ONE_SHOT 4'h0
`define MODE_CONTINUOUS 4'h1
`define MODE_COUNTER 4'h2
`define MODE_PWM_SINGLE 4'h3
`define MODE_CAPTURE 4'h4
`define MODE_COMPARE 4'h5
`define MODE_GATED 4'h6
`define MODE_CAPTURE_COMPARE 4'h7

// prescaler depth: divide by up to two to the seventh
`define PRESCALE_W 7

`endif

/* File: verilog/pin_edge_sync.v */
// two-stage synchroniser for an external pin with edge detection
// assumes the pin is asynchronous to clk_i
`timescale 1ns/1ns
`default_nettype none

module pin_edge_sync (
    input wire clk_i,
    input wire rst_i,
    input wire pin_i,
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);

    reg meta;
    reg stable;
    reg prev;

    // meta feeds only stable
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            stable <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin_i;
            stable <= meta;
            prev <= stable;
        end
    end

    assign level_o = stable;
    assign rise_o = stable & ~prev;
    assign fall_o = ~stable & prev;

endmodule // pin_edge_sync

`default_nettype wire

/* File: verilog/tick_prescaler.v */
// power-of-two prescaler: passes one of every 2**sel_i input ticks
// assumes tick_i is a one-cycle pulse on clk_i
`timescale 1ns/1ns
`default_nettype none

module tick_prescaler #(
    parameter WIDTH = 7
) (
    input wire clk_i,
    input wire rst_i,
    input wire clear_i,
    input wire tick_i,
    input wire [2:0] sel_i,
    output wire tick_o
);

    reg [WIDTH-1:0] cnt;
    wire [WIDTH-1:0] mask;

    assign mask = ~({WIDTH{1'b1}} << sel_i);
    assign tick_o = tick_i & ((cnt & mask) == mask);

    always @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            cnt <= {WIDTH{1'b0}};
        end else if (tick_i) begin
            cnt <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule // tick_prescaler

`default_nettype wire

/* File: verilog/timer_mode_polarity_control.v */
// 16-bit general timer: control byte, polarity, prescaler and mode logic
// assumes a byte register port on CLK_I and an asynchronous timer input pin
`include "timer_map.vh"
`timescale 1ns/1ns
`default_nettype none

module timer_mode_polarity_control #(
    parameter PRESCALE_W = `PRESCALE_W
) (
    input wire CLK_I,
    input wire RST_I,
    input wire [`ADDR_W-1:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [7:0] RDATA_O,
    input wire TIN_I,
    output reg TOUT_O,
    output reg IRQ_O
);

    reg [7:0] timer_control_one;
    reg [7:0] timer_control_zero;
    reg [15:0] count;
    reg [15:0] reload;
    reg [15:0] pwm_value;
    reg [`IRQ_W-1:0] irq_status;
    reg [`IRQ_W-1:0] irq_mask;
    reg started;
    reg one_shot_done;
    reg pulse_pending;
    reg raw_tick;
    reg [7:0] next_rdata;

    wire run_enable_bit;
    wire io_polarity_bit;
    wire [2:0] prescale_field;
    wire [2:0] mode_select_field;
    wire [3:0] mode;
    wire tin_level;
    wire tin_rise;
    wire tin_fall;
    wire active_edge;
    wire gate_active;
    wire gate_end_edge;
    wire tick;
    wire at_reload;
    wire pwm_match;
    wire capture_event;
    wire start_event;
    wire gate_event;
    wire [`IRQ_W-1:0] irq_events;
    wire [`IRQ_W-1:0] irq_clear;
    wire [`IRQ_W-1:0] next_irq_status;

    assign run_enable_bit = timer_control_one[`RUN_ENABLE_BIT];
    assign io_polarity_bit = timer_control_one[`IO_POLARITY_BIT];
    assign prescale_field = timer_control_one[`PRESCALE_HI:`PRESCALE_LO];
    assign mode_select_field =
        timer_control_one[`MODE_SELECT_HI:`MODE_SELECT_LO];
    assign mode = {timer_control_zero[`MODE_HIGH_BIT],
                   mode_select_field};

    pin_edge_sync u_tin_sync (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .pin_i(TIN_I),
        .level_o(tin_level),
        .rise_o(tin_rise),
        .fall_o(tin_fall)
    );

    // polarity 0 selects rising edges and high gate, 1 the opposite
    assign active_edge = io_polarity_bit ? tin_fall : tin_rise;
    assign gate_active = io_polarity_bit ? ~tin_level : tin_level;
    assign gate_end_edge = io_polarity_bit ? tin_rise : tin_fall;

    // what advances the prescaler in each mode
    always @* begin
        raw_tick = 1'b0;
        case (mode)
            `MODE_ONE_SHOT: raw_tick = ~one_shot_done;
            `MODE_CONTINUOUS: raw_tick = 1'b1;
            `MODE_COUNTER: raw_tick = active_edge;
            `MODE_PWM_SINGLE: raw_tick = 1'b1;
            `MODE_CAPTURE: raw_tick = 1'b1;
            `MODE_COMPARE: raw_tick = 1'b1;
            `MODE_GATED: raw_tick = gate_active;
            `MODE_CAPTURE_COMPARE: raw_tick = started;
            default: raw_tick = 1'b0;
        endcase
    end

    tick_prescaler #(
        .WIDTH(PRESCALE_W)
    ) u_prescaler (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .clear_i(~run_enable_bit),
        .tick_i(run_enable_bit & raw_tick),
        .sel_i(prescale_field),
        .tick_o(tick)
    );

    assign at_reload = tick & (count == reload);
    assign pwm_match = tick & (count == pwm_value)
        & (mode == `MODE_PWM_SINGLE);
    assign capture_event = run_enable_bit & active_edge
        & ((mode == `MODE_CAPTURE)
        | ((mode == `MODE_CAPTURE_COMPARE) & started));
    assign start_event = run_enable_bit & active_edge & ~started
        & (mode == `MODE_CAPTURE_COMPARE);
    assign gate_event = run_enable_bit & gate_end_edge
        & (mode == `MODE_GATED);

    // register writes; timer logic wins over a software write
    always @(posedge CLK_I) begin
        if (RST_I) begin
            timer_control_one <= `CTL_RESET;
            timer_control_zero <= `CTL_RESET;
            reload <= `RELOAD_RESET;
        end else if (WR_I) begin
            case (ADDR_I)
                `ADDR_CTL1: timer_control_one <= WDATA_I;
                `ADDR_CTL0: timer_control_zero <= WDATA_I;
                `ADDR_RELOAD_HI: reload[15:8] <= WDATA_I;
                `ADDR_RELOAD_LO: reload[7:0] <= WDATA_I;
                default: reload <= reload;
            endcase
        end
    end

    // counter: runs from the restart value up to reload
    always @(posedge CLK_I) begin
        if (RST_I) begin
            count <= `COUNT_RESET;
        end else if (at_reload) begin
            count <= `COUNT_RESTART;
        end else if (tick) begin
            count <= count + `COUNT_STEP;
        end else if (WR_I && ADDR_I == `ADDR_COUNT_HI) begin
            count[15:8] <= WDATA_I;
        end else if (WR_I && ADDR_I == `ADDR_COUNT_LO) begin
            count[7:0] <= WDATA_I;
        end
    end

    // pwm value, also the capture holding register
    always @(posedge CLK_I) begin
        if (RST_I) begin
            pwm_value <= `PWM_RESET;
        end else if (capture_event) begin
            pwm_value <= count;
        end else if (WR_I && ADDR_I == `ADDR_PWM_HI) begin
            pwm_value[15:8] <= WDATA_I;
        end else if (WR_I && ADDR_I == `ADDR_PWM_LO) begin
            pwm_value[7:0] <= WDATA_I;
        end
    end

    // run state flags, cleared whenever the timer is off
    always @(posedge CLK_I) begin
        if (RST_I || !run_enable_bit) begin
            started <= 1'b0;
            one_shot_done <= 1'b0;
        end else begin
            if (start_event) begin
                started <= 1'b1;
            end
            if (at_reload && mode == `MODE_ONE_SHOT) begin
                one_shot_done <= 1'b1;
            end
        end
    end

    // timer output
    always @(posedge CLK_I) begin
        if (RST_I) begin
            TOUT_O <= 1'b0;
            pulse_pending <= 1'b0;
        end else if (!run_enable_bit) begin
            // follows the stored polarity one cycle after the write
            TOUT_O <= io_polarity_bit;
            pulse_pending <= 1'b0;
        end else begin
            case (mode)
                `MODE_ONE_SHOT: begin
                    if (pulse_pending) begin
                        TOUT_O <= ~TOUT_O;
                        pulse_pending <= 1'b0;
                    end else if (at_reload) begin
                        TOUT_O <= ~TOUT_O;
                        pulse_pending <= 1'b1;
                    end
                end
                `MODE_PWM_SINGLE: begin
                    if (at_reload) begin
                        TOUT_O <= io_polarity_bit;
                    end else if (pwm_match) begin
                        TOUT_O <= ~io_polarity_bit;
                    end
                end
                `MODE_CONTINUOUS: begin
                    if (at_reload) begin
                        TOUT_O <= ~TOUT_O;
                    end
                end
                `MODE_COUNTER,
                `MODE_CAPTURE: begin
                    if (at_reload) begin
                        TOUT_O <= ~TOUT_O;
                    end
                end
                `MODE_COMPARE: begin
                    if (at_reload) begin
                        TOUT_O <= ~TOUT_O;
                    end
                end
                `MODE_GATED: begin
                    if (at_reload) begin
                        TOUT_O <= ~TOUT_O;
                    end
                end
                `MODE_CAPTURE_COMPARE: begin
                    if (at_reload) begin
                        TOUT_O <= ~TOUT_O;
                    end
                end
                default: begin
                    TOUT_O <= TOUT_O;
                end
            endcase
        end
    end

    // sticky interrupt status: a new event wins over a write-one clear
    assign irq_events[`IRQ_RELOAD] = at_reload;
    assign irq_events[`IRQ_CAPTURE] = capture_event;
    assign irq_events[`IRQ_GATE] = gate_event;
    assign irq_clear = (WR_I && ADDR_I == `ADDR_IRQ_STATUS)
        ? WDATA_I[`IRQ_W-1:0] : `IRQ_ZERO;
    assign next_irq_status = (irq_status & ~irq_clear) | irq_events;

    always @(posedge CLK_I) begin
        if (RST_I) begin
            irq_status <= `IRQ_ZERO;
            irq_mask <= `IRQ_ZERO;
            IRQ_O <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            if (WR_I && ADDR_I == `ADDR_IRQ_MASK) begin
                irq_mask <= WDATA_I[`IRQ_W-1:0];
            end
            IRQ_O <= |(irq_status & irq_mask);
        end
    end

    // read data, valid in the cycle after the read strobe
    always @* begin
        next_rdata = `BYTE_ZERO;
        case (ADDR_I)
            `ADDR_COUNT_HI: next_rdata = count[15:8];
            `ADDR_COUNT_LO: next_rdata = count[7:0];
            `ADDR_RELOAD_HI: next_rdata = reload[15:8];
            `ADDR_RELOAD_LO: next_rdata = reload[7:0];
            `ADDR_PWM_HI: next_rdata = pwm_value[15:8];
            `ADDR_PWM_LO: next_rdata = pwm_value[7:0];
            `ADDR_CTL0: next_rdata = timer_control_zero;
            `ADDR_CTL1: next_rdata = timer_control_one;
            `ADDR_IRQ_STATUS: next_rdata = {5'h00, irq_status};
            `ADDR_IRQ_MASK: next_rdata = {5'h00, irq_mask};
            default: next_rdata = `BYTE_ZERO;
        endcase
    end

    always @(posedge CLK_I) begin
        if (RST_I) begin
            RDATA_O <= `BYTE_ZERO;
        end else if (RD_I) begin
            RDATA_O <= next_rdata;
        end else begin
            RDATA_O <= `BYTE_ZERO;
        end
    end

endmodule // timer_mode_polarity_control

`default_nettype wire

/* File: sim/timer_mode_polarity_control_sva.sv */
// checker for the timer control block, watching its ports only
// assumes it is bound to timer_mode_polarity_control
`include "timer_map.vh"
`timescale 1ns/1ns
`default_nettype none
module timer_mode_polarity_control_sva (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [`ADDR_W-1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic TOUT_O,
    input wire logic IRQ_O
);
    logic [7:0] ctl, ctl_d;
    logic [`IRQ_W-1:0] msk;
    logic hb, hb_d, tout_d, seen;
    logic [15:0] rld, gap;
    // run: enabled and unchanged since the previous cycle
    wire run = ctl == ctl_d && hb == hb_d && ctl[`RUN_ENABLE_BIT];
    wire os = run && !hb && ctl[2:0] == 3'h0;
    wire cont = run && !hb && ctl[5:0] == 6'h01;
    wire chg = tout_d != TOUT_O;
    always @(posedge CLK_I) begin
        ctl_d <= ctl;
        hb_d <= hb;
        tout_d <= TOUT_O;
        gap <= chg ? 16'h0001 : gap + 16'h0001;
        seen <= cont && (seen || chg);
        if (RST_I) begin
            ctl <= `CTL_RESET;
            hb <= 1'b0;
            msk <= `IRQ_ZERO;
            rld <= `RELOAD_RESET;
        end else if (WR_I) begin
            case (ADDR_I)
                `ADDR_CTL0: hb <= WDATA_I[`MODE_HIGH_BIT];
                `ADDR_CTL1: ctl <= WDATA_I;
                `ADDR_IRQ_MASK: msk <= WDATA_I[`IRQ_W-1:0];
                `ADDR_RELOAD_HI: rld[15:8] <= WDATA_I;
                `ADDR_RELOAD_LO: rld[7:0] <= WDATA_I;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_back;
        chg ##1 !chg;
    endsequence
    // first edge of a pulse only, so the return edge is not taken as a start
    sequence s_first;
        os && chg && !$past(chg);
    endsequence
    a_read_idle: assert property (!RD_I |=> RDATA_O == `BYTE_ZERO)
        else $error("read data not zero when idle");
    a_ctl_readback: assert property (RD_I && ADDR_I == `ADDR_CTL1
        |=> RDATA_O == $past(ctl)) else $error("control readback wrong");
    a_unmapped_zero: assert property (RD_I && (ADDR_I < `ADDR_COUNT_HI
        || ADDR_I > `ADDR_IRQ_MASK) |=> RDATA_O == `BYTE_ZERO)
        else $error("unmapped read not zero");
    a_disabled_pol: assert property (!ctl[7]
        |=> TOUT_O == $past(ctl[6]))
        else $error("disabled output differs from polarity");
    a_oneshot_pulse: assert property (s_first |=> s_back)
        else $error("one-shot pulse not one cycle");
    a_toggle_period: assert property (cont && seen && chg
        |-> gap == rld) else $error("toggle period differs from reload");
    a_high_hold: assert property (run && hb |-> !chg)
        else $error("output moved in unsupported mode");
    a_irq_masked: assert property (msk == `IRQ_ZERO |=> !IRQ_O)
        else $error("interrupt high while fully masked");
endmodule // timer_mode_polarity_control_sva
`default_nettype wire

/* File: sim/timer_mode_polarity_control_tb.sv */
// self-checking bench for the timer control block
// assumes the design and its checker are compiled before it
`include "timer_map.vh"
`timescale 1ns/1ns
`default_nettype none
module timer_mode_polarity_control_tb;
    logic CLK_I = 1'b0, RST_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;
    logic TIN_I = 1'b0, rd_d = 1'b0, pb;
    logic [11:0] ADDR_I = 12'h000;
    logic [7:0] WDATA_I = 8'h00, v;
    logic [2:0] m;
    wire [7:0] RDATA_O;
    wire TOUT_O, IRQ_O;
    logic [7:0] q[$];
    int num_errors = 0, total_checks = 0, seed = 32'hF8CF, n;
    logic [11:0] ra[10] = '{12'hF07, 12'hF06, 12'hF02, 12'hF03, 12'hF04,
        12'hF05, 12'hF00, 12'hF01, 12'hF0A, 12'h000};
    logic [7:0] rv[10] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
        8'h00, 8'h01, 8'h00, 8'h00};
    logic [2:0] tg[3] = '{3'h1, 3'h5, 3'h6};
    logic [2:0] tm[4] = '{3'h2, 3'h4, 3'h6, 3'h7};
    logic [7:0] tr0[4] = '{8'h02, 8'h02, 8'h00, 8'h00};
    logic [7:0] tr1[4] = '{8'h01, 8'h00, 8'h04, 8'h00};
    logic [7:0] tf[4] = '{8'h02, 8'h02, 8'h04, 8'h00};
    timer_mode_polarity_control timer_mode_polarity_control_i (
        .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
        .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .TIN_I(TIN_I),
        .TOUT_O(TOUT_O), .IRQ_O(IRQ_O));
    always #5 CLK_I = ~CLK_I;
    always @(posedge CLK_I) rd_d <= RD_I;
    always @(negedge CLK_I) if (rd_d) chk(RDATA_O, q.pop_front());
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge CLK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        q.push_back(e);
        @(posedge CLK_I);
        RD_I <= 1'b0;
    endtask
    // counts cycles until the output moves, giving up at lim
    task wait_chg(input int lim, output int c);
        logic t;
        t = TOUT_O;
        c = 0;
        while (TOUT_O === t && c < lim) begin
            @(negedge CLK_I);
            c++;
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge CLK_I);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done;
    end
    initial begin
        repeat (16) @(posedge CLK_I);
        RST_I <= 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i]);
        $display("reset test done");
        repeat (8) begin
            v = 8'($random(seed)) & 8'h7F;
            wr(`ADDR_CTL1, v);
            rd(`ADDR_CTL1, v);
            @(negedge CLK_I);
            chk({7'h00, TOUT_O}, {7'h00, v[6]});
        end
        $display("polarity test done");
        @(posedge CLK_I);
        TIN_I <= 1'b1;
        wr(`ADDR_RELOAD_HI, 8'h00);
        wr(`ADDR_RELOAD_LO, 8'h05);
        for (int i = 0; i < 3; i++) begin
            wr(`ADDR_CTL1, {2'b10, 3'(i), tg[i]});
            wait_chg(200, n);
            wait_chg(200, n);
            chk(8'(n), 8'(5 << i));
        end
        chk({7'h00, IRQ_O}, 8'h00);
        wr(`ADDR_CTL1, 8'h01);
        rd(`ADDR_IRQ_STATUS, 8'h01);
        wr(`ADDR_IRQ_MASK, 8'h01);
        repeat (2) @(negedge CLK_I);
        chk({7'h00, IRQ_O}, 8'h01);
        wr(`ADDR_IRQ_STATUS, 8'h01);
        repeat (2) @(negedge CLK_I);
        chk({7'h00, IRQ_O}, 8'h00);
        rd(`ADDR_IRQ_STATUS, 8'h00);
        $display("toggle test done");
        wr(`ADDR_PWM_LO, 8'h03);
        for (int k = 0; k < 4; k++) begin
            pb = k[0];
            m = k[1] ? 3'h3 : 3'h0;
            wr(`ADDR_CTL1, {1'b0, pb, 3'h0, m});
            wr(`ADDR_COUNT_LO, 8'h01);
            wr(`ADDR_CTL1, {1'b1, pb, 3'h0, m});
            wait_chg(200, n);
            chk({7'h00, TOUT_O}, {7'h00, ~pb});
            wait_chg(200, n);
            chk({7'h00, TOUT_O}, {7'h00, pb});
            if (m == 3'h0) chk(8'(n), 8'h01);
        end
        $display("pulse test done");
        wr(`ADDR_CTL0, 8'h80);
        wr(`ADDR_CTL1, 8'h81);
        wait_chg(60, n);
        chk(8'(n), 8'h3C);
        // stop the timer before the reload changes under a running period
        wr(`ADDR_CTL1, 8'h01);
        wr(`ADDR_CTL0, 8'h00);
        $display("mode code test done");
        TIN_I <= 1'b0;
        wr(`ADDR_RELOAD_HI, 8'hFF);
        wr(`ADDR_RELOAD_LO, 8'hFF);
        for (int k = 0; k < 8; k++) begin
            pb = k[0];
            wr(`ADDR_CTL1, {1'b0, pb, 3'h0, tm[k/2]});
            wr(`ADDR_COUNT_HI, 8'h00);
            wr(`ADDR_COUNT_LO, 8'h01);
            wr(`ADDR_IRQ_STATUS, 8'h07);
            wr(`ADDR_CTL1, {1'b1, pb, 3'h0, tm[k/2]});
            TIN_I <= 1'b1;
            repeat (6) @(posedge CLK_I);
            v = k < 2 ? 8'h01 : 8'h08;
            rd({4'hF, v}, pb ? tr1[k/2] : tr0[k/2]);
            TIN_I <= 1'b0;
            repeat (6) @(posedge CLK_I);
            rd({4'hF, v}, tf[k/2]);
        end
        // capture/compare: first rise starts, the next rise captures
        wr(`ADDR_CTL1, 8'h07);
        wr(`ADDR_IRQ_STATUS, 8'h07);
        wr(`ADDR_CTL1, 8'h87);
        for (int j = 0; j < 3; j++) begin
            TIN_I <= ~TIN_I;
            repeat (6) @(posedge CLK_I);
        end
        rd(`ADDR_IRQ_STATUS, 8'h02);
        $display("edge test done");
        repeat (4) @(posedge CLK_I);
        test_done;
    end
endmodule // timer_mode_polarity_control_tb
bind timer_mode_polarity_control timer_mode_polarity_control_sva
    timer_mode_polarity_control_sva_i (.CLK_I(CLK_I), .RST_I(RST_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .RDATA_O(RDATA_O), .TOUT_O(TOUT_O), .IRQ_O(IRQ_O));
`default_nettype wire
